// ---- pkg/sarcc_defs.svh ----
`ifndef SARCC_DEFS_SVH
`define SARCC_DEFS_SVH
// Conversion bit count
`define SARCC_RES_BITS       18
// Clock period in ns
`define SARCC_CLK_NS         20
// Time spent on each bit decision, ns
`define SARCC_BIT_NS         80
// Self-timed acquisition in free-running mode, ns
`define SARCC_ACQ_NS         200
`define SARCC_BIT_CYC        ((`SARCC_BIT_NS + `SARCC_CLK_NS - 1) / `SARCC_CLK_NS)
`define SARCC_ACQ_CYC        ((`SARCC_ACQ_NS + `SARCC_CLK_NS - 1) / `SARCC_CLK_NS)
`define SARCC_RESULT_RST     18'h00000
`endif

// ---- pkg/sarcc_pkg.sv ----
`include "sarcc_defs.svh"
package sarcc_pkg;
  typedef enum logic [3:0] {
    SARCC_IDLE = 4'b0001,
    SARCC_CONV = 4'b0010,
    SARCC_DONE = 4'b0100,
    SARCC_ACQ  = 4'b1000
  } sarcc_state_t;

  typedef struct packed {
    logic        busy;
    logic        core_sleep;
    logic        ref_buf_on;
  } sarcc_status_t;
endpackage

// ---- src/sarcc_sync.sv ----
module sarcc_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic d_i,
  output logic      q_o
);
  logic meta_q;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      meta_q <= RST_VAL;
      q_o    <= RST_VAL;
    end else begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end
endmodule

// ---- src/sarcc_core.sv ----
`include "sarcc_defs.svh"
// Summary of operation
// [R1] A conversion starts only from the host's active-low convert strobe.
// [R2] Falling strobe edge ends acquisition and begins the conversion phase.
// [R3] A running conversion ignores strobe activity and sleep request until done.
// [R4] Chip select and read strobe have no effect on conversion start.
// [R5] Eighteen bits resolved MSB first, then code presented and busy dropped.
// [R6] Strobe still low at busy fall: self-timed acquisition, then auto restart.
// [R7] Host must pulse strobe low once after power-up before free running.
// [R8] Free-running rate may slightly exceed rated throughput; host tolerates it.
// [R9] Core enters reduced power at end of every conversion phase.
// [R10] Readout interface stays usable while the core is asleep.
// [R11] Reference buffer is off while its disable input is high.
// [R12] Busy high from conversion start until result ready, low during acquisition.
module sarcc_core
  import sarcc_pkg::*;
#(
  parameter int RES_BITS = `SARCC_RES_BITS,
  parameter int BIT_CYC  = `SARCC_BIT_CYC,
  parameter int ACQ_CYC  = `SARCC_ACQ_CYC
) (
  // Clock and reset
  input  wire logic                clk_i,
  input  wire logic                rst_n_i,
  // Conversion control pins
  input  wire logic                convert_strobe_n_i,
  input  wire logic                sleep_request_i,
  input  wire logic                ref_buffer_off_i,
  input  wire logic                chip_select_n_i,
  input  wire logic                read_strobe_n_i,
  // Comparator decision from the analog core
  input  wire logic                cmp_high_i,
  // Status and result
  output logic                     busy_o,
  output logic                     core_sleep_o,
  output logic                     ref_buf_en_o,
  output logic                     readout_ready_o,
  output logic [RES_BITS-1:0]      result_o,
  output sarcc_status_t            status_o
);
  localparam int CW = $clog2(BIT_CYC + ACQ_CYC + 1);
  localparam int BW = $clog2(RES_BITS + 1);

  logic                strobe_n_s;
  logic                cmp_s;
  logic                sleep_s;
  logic                rbuf_off_s;
  logic                strobe_n_q;
  logic                fall;
  sarcc_state_t        state_q;
  logic [CW-1:0]       tick_q;
  logic [BW-1:0]       bit_q;
  logic [RES_BITS-1:0] trial_q;
  logic                started_q;

  sarcc_sync #(.RST_VAL(1'b1)) u_sync_cnv (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .d_i     (convert_strobe_n_i),
    .q_o     (strobe_n_s)
  );
  sarcc_sync #(.RST_VAL(1'b0)) u_sync_cmp (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .d_i     (cmp_high_i),
    .q_o     (cmp_s)
  );
  sarcc_sync #(.RST_VAL(1'b0)) u_sync_slp (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .d_i     (sleep_request_i),
    .q_o     (sleep_s)
  );
  sarcc_sync #(.RST_VAL(1'b1)) u_sync_buf (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .d_i     (ref_buffer_off_i),
    .q_o     (rbuf_off_s)
  );

  // Strobe edge detect on the synchronised level
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      strobe_n_q <= 1'b1;
    end else begin
      strobe_n_q <= strobe_n_s;
    end
  end

  // Outside free running only the strobe edge starts; chip select and read strobe are not looked at
  assign fall = strobe_n_q & ~strobe_n_s; // [R1] [R2] [R4]

  // Free running is armed only once a real edge has been seen
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      started_q <= 1'b0;
    end else if (fall) begin
      started_q <= 1'b1; // [R7]
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_q <= SARCC_IDLE;
      tick_q  <= '0;
      bit_q   <= '0;
      trial_q <= '0;
    end else begin
      case (state_q)
        SARCC_IDLE, SARCC_DONE: begin
          if (fall) begin
            state_q <= SARCC_CONV; // [R2]
            tick_q  <= '0;
            bit_q   <= BW'(RES_BITS - 1);
            trial_q <= '0;
          end else if (state_q == SARCC_DONE && !strobe_n_s && started_q) begin
            state_q <= SARCC_ACQ; // [R6]
            tick_q  <= '0;
          end else begin
            state_q <= SARCC_IDLE;
          end
        end
        SARCC_CONV: begin
          // No edge or sleep request can disturb this state
          if (tick_q == CW'(BIT_CYC - 1)) begin // [R3]
            tick_q <= '0;
            trial_q[bit_q] <= cmp_s; // [R5]
            if (bit_q == '0) begin
              state_q <= SARCC_DONE;
            end else begin
              bit_q <= bit_q - BW'(1);
            end
          end else begin
            tick_q <= tick_q + CW'(1);
          end
        end
        SARCC_ACQ: begin
          // Self-timed acquisition; may outrun the rated rate
          if (tick_q == CW'(ACQ_CYC - 1)) begin // [R8]
            state_q <= SARCC_CONV; // [R6]
            tick_q  <= '0;
            bit_q   <= BW'(RES_BITS - 1);
            trial_q <= '0;
          end else begin
            tick_q <= tick_q + CW'(1);
          end
        end
        default: begin
          state_q <= SARCC_IDLE;
        end
      endcase
    end
  end

  // Result register updates once per conversion
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      result_o <= `SARCC_RESULT_RST;
    end else if (state_q == SARCC_CONV && tick_q == CW'(BIT_CYC - 1) && bit_q == '0) begin
      result_o <= {trial_q[RES_BITS-1:1], cmp_s}; // [R5]
    end
  end

  assign busy_o          = (state_q == SARCC_CONV); // [R12]
  assign core_sleep_o    = ~busy_o | (sleep_s & ~busy_o); // [R9] [R3]
  assign ref_buf_en_o    = ~rbuf_off_s; // [R11]
  assign readout_ready_o = 1'b1; // [R10]
  assign status_o        = '{busy: busy_o, core_sleep: core_sleep_o, ref_buf_on: ref_buf_en_o};

  sequence s_conv_run;
    busy_o [*8];
  endsequence

  a_start_busy: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R2]
    (fall && !busy_o && state_q != SARCC_ACQ) |=> busy_o)
    else $error("busy did not rise after strobe edge");
  a_no_abort: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R3]
    (busy_o && tick_q != CW'(BIT_CYC - 1)) |=> busy_o)
    else $error("conversion aborted early");
  a_conv_len: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R5]
    $rose(busy_o) |-> s_conv_run)
    else $error("conversion shorter than expected");
  a_bits_msb: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R5]
    $rose(busy_o) |-> bit_q == BW'(RES_BITS - 1))
    else $error("conversion not started at MSB");
  a_auto_restart: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R6]
    (state_q == SARCC_ACQ && !fall) |-> ##[1:20] busy_o)
    else $error("free-running restart missing");
  a_arm_first: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R7]
    (state_q == SARCC_ACQ) |-> started_q)
    else $error("free running before first strobe");
  a_sleep_acq: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R9]
    $fell(busy_o) |-> core_sleep_o)
    else $error("core not asleep after conversion");
  a_ref_buf: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R11]
    ($past(rst_n_i) && $past(rst_n_i, 2)) |-> ref_buf_en_o == !$past(ref_buffer_off_i, 2))
    else $error("reference buffer state wrong");
  a_result_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R12]
    (!busy_o && $past(!busy_o)) |-> $stable(result_o))
    else $error("result changed while idle");
endmodule

// ---- bench/sarcc_host_model.sv ----
module sarcc_host_model (
  // Clock
  input  wire logic clk_i,
  // Commands from the bench
  input  wire logic pulse_i,
  input  wire logic hold_i,
  // Strobe to the converter
  output logic      convert_strobe_n_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] cnt_q = 2'h0;
  initial convert_strobe_n_o = 1'b1;
  // Short low pulse per start, or held low for free running
  always @(posedge clk_i) begin
    cnt_q <= pulse_i ? 2'h3 : (cnt_q != 2'h0 ? cnt_q - 2'h1 : 2'h0);
    convert_strobe_n_o <= #1 !(hold_i || pulse_i || cnt_q > 2'h1);
  end
endmodule

// ---- bench/tb.sv ----
module tb
  import sarcc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int CONV_LEN = 72;
  localparam int ACQ_LEN  = 10;
  logic clk_i = 1'b0, rst_n_i = 1'b0, pulse = 1'b0, hold = 1'b0, sleep_req = 1'b0;
  logic ref_off = 1'b0, cs_n = 1'b1, rd_n = 1'b1, cmp = 1'b0;
  logic strobe_n, busy, sleep, buf_en, ready;
  logic [17:0] result, pat;
  sarcc_status_t status;
  int n_errors = 0, compares = 0, seed = 64136, wait_n;
  always #10 clk_i = ~clk_i;
  sarcc_host_model u_sarcc_host_model (.clk_i(clk_i), .pulse_i(pulse), .hold_i(hold), .convert_strobe_n_o(strobe_n));
  sarcc_core u_sarcc_core (.clk_i(clk_i), .rst_n_i(rst_n_i), .convert_strobe_n_i(strobe_n),
    .sleep_request_i(sleep_req), .ref_buffer_off_i(ref_off), .chip_select_n_i(cs_n),
    .read_strobe_n_i(rd_n), .cmp_high_i(cmp), .busy_o(busy), .core_sleep_o(sleep),
    .ref_buf_en_o(buf_en), .readout_ready_o(ready), .result_o(result), .status_o(status));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic test_done();
    if (n_errors == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Self-timed acquisition gap seen by the bench, no slack below ACQ_LEN and two cycles of slack above
  function automatic logic gap_ok(input int w);
    return w >= ACQ_LEN && w <= ACQ_LEN + 2;
  endfunction
  task automatic step();
    @(posedge clk_i);
    #1;
  endtask
  // Waits for busy, then counts its length, disturbing strobe and sleep inputs when disturb is set
  task automatic run_conv(input logic [17:0] exp, input bit disturb);
    int n;
    n = 0;
    wait_n = 0;
    while (busy !== 1'b1 && wait_n < 20) begin
      step();
      wait_n++;
    end
    if (wait_n == 20) begin
      n_errors++;
      test_done();
    end
    while (busy === 1'b1 && n < 200) begin
      step();
      n++;
      if (n < CONV_LEN) cmp = exp[17 - n / 4];
      pulse = disturb && n == 20;
      sleep_req = disturb && n > 30 && n < 50;
    end
    chk("busy_len", CONV_LEN, n);
    chk("result", exp, result);
  endtask
  // Interface strobes toggle freely; conversions must not care
  always @(posedge clk_i) begin
    cs_n <= #1 1'($random(seed));
    rd_n <= #1 1'($random(seed));
  end
  always @(negedge clk_i) if (rst_n_i) begin
    chk("sleep", !busy, sleep);
    chk("ready", 1'b1, ready);
    chk("status", {busy, sleep, buf_en}, status);
  end
  initial begin
    repeat (20) @(posedge clk_i);
    #1 rst_n_i = 1'b1;
    chk("rst_result", 18'h00000, result);
    repeat (50) begin
      step();
      chk("idle", 1'b0, busy);
    end
    for (int i = 0; i < 6; i++) begin
      pat = (i == 0) ? 18'h20000 : 18'($random(seed));
      ref_off = 1'($random(seed));
      pulse = 1'b1;
      step();
      pulse = 1'b0;
      run_conv(pat, i[0]);
      chk("start_wait", 1'b1, wait_n <= 6);
      chk("buf_en", !ref_off, buf_en);
    end
    cmp = 1'b1;
    hold = 1'b1;
    run_conv(18'h3FFFF, 1'b0);
    cmp = 1'b0;
    run_conv(18'h00000, 1'b0);
    chk("acq_gap", 1'b1, gap_ok(wait_n));
    hold = 1'b0;
    repeat (120) step();
    chk("stop", 1'b0, busy);
    test_done();
  end
endmodule
